// *** design/ubw_port.sv ***
// serial port: auto-wake, break transmit and synchronous master transmit
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
module ubw_port
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic shift_clock_pin_o,
   output logic shift_clock_pin_oe,
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe,
   output logic receive_irq_flag,
   output logic transmit_irq_flag
);
   typedef enum logic [1:0] {UBW_IDLE, UBW_LOAD, UBW_SHIFT} ubw_tx_state_t;

   logic [7:0] rx_status;
   logic [7:0] tx_status;
   logic [7:0] baud_ctrl;
   logic [7:0] div_high;
   logic [7:0] div_low;
   logic [7:0] transmit_buffer;
   logic buffer_full;
   logic tx_irq_enable;
   logic line_meta;
   logic line_sync;
   logic line_prev;
   logic woke;
   ubw_tx_state_t state;
   logic [14:0] transmit_shifter;
   logic [3:0] bits_left;
   logic frame_is_break;
   logic [15:0] baud_count;
   logic baud_tick;
   logic clk_phase;
   logic access;
   logic wr;
   logic rd;
   logic sync_master;
   logic port_on;
   logic [15:0] divisor;
   logic fall_edge;
   logic rise_edge;
   logic break_done;
   logic last_bit;

   assign access = psel && penable && pready;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign port_on = rx_status[ubw_pkg::RX_PORT_EN];
   // R15 master mode select
   assign sync_master = port_on && tx_status[ubw_pkg::TX_SYNC]
      && tx_status[ubw_pkg::TX_CLK_SRC];
   assign divisor = baud_ctrl[ubw_pkg::BC_WIDE] ? {div_high, div_low} : {8'h00, div_low};
   assign fall_edge = line_prev && !line_sync;
   assign rise_edge = !line_prev && line_sync;
   assign last_bit = (state == UBW_SHIFT) && baud_tick && (bits_left == 4'd1)
      && (!sync_master || clk_phase);
   assign break_done = last_bit && frame_is_break;

   // apb answer: zero wait states, error on unmapped offsets
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready
            && (paddr[1:0] != 2'b00 || paddr > ubw_pkg::OFS_FLAGS);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            ubw_pkg::OFS_RX_STATUS: prdata <= {24'h000000, rx_status};
            ubw_pkg::OFS_TX_BUFFER: prdata <= {24'h000000, transmit_buffer};
            // R10 R21 empty bit reflects the shifter, break frames too
            ubw_pkg::OFS_TX_STATUS: prdata <= {24'h000000, tx_status[7:2],
               state == UBW_IDLE, tx_status[0]};
            ubw_pkg::OFS_BAUD_CTRL: prdata <= {24'h000000, baud_ctrl[7],
               !woke && line_sync, baud_ctrl[5:0]};
            ubw_pkg::OFS_DIV_HIGH: prdata <= {24'h000000, div_high};
            ubw_pkg::OFS_DIV_LOW: prdata <= {24'h000000, div_low};
            // R4 receive data is dummy after a wake
            ubw_pkg::OFS_RX_DATA: prdata <= 32'h0000_0000;
            ubw_pkg::OFS_FLAGS: prdata <= {29'h00000000, tx_irq_enable,
               transmit_irq_flag, receive_irq_flag};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // plain configuration registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         rx_status <= ubw_pkg::REG_RESET;
         div_high <= ubw_pkg::REG_RESET;
         div_low <= ubw_pkg::REG_RESET;
         tx_irq_enable <= 1'b0;
      end
      else if (wr)
      begin
         if (paddr == ubw_pkg::OFS_RX_STATUS)
         begin
            rx_status <= pwdata[7:0] & ubw_pkg::RX_STATUS_WMASK;
         end
         if (paddr == ubw_pkg::OFS_DIV_HIGH)
         begin
            div_high <= pwdata[7:0];
         end
         if (paddr == ubw_pkg::OFS_DIV_LOW)
         begin
            div_low <= pwdata[7:0];
         end
         if (paddr == ubw_pkg::OFS_FLAGS)
         begin
            tx_irq_enable <= pwdata[ubw_pkg::FL_TX_IRQ_EN];
         end
      end
   end

   // transmit status: software write wins over the hardware break clear
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         tx_status <= ubw_pkg::TX_STATUS_RESET;
      end
      else if (wr && paddr == ubw_pkg::OFS_TX_STATUS)
      begin
         tx_status <= pwdata[7:0] & ubw_pkg::TX_STATUS_WMASK;
      end
      // R9 clear after break stop bit
      else if (break_done)
      begin
         tx_status[ubw_pkg::TX_BREAK] <= 1'b0;
      end
   end

   // baud control: wake_enable auto-clears on the rising edge after a wake
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         baud_ctrl <= ubw_pkg::REG_RESET;
      end
      else if (wr && paddr == ubw_pkg::OFS_BAUD_CTRL)
      begin
         baud_ctrl <= pwdata[7:0] & ubw_pkg::BAUD_CTRL_WMASK;
      end
      // R3 R6 auto-clear, no phase enable needed
      else if (woke && rise_edge)
      begin
         baud_ctrl[ubw_pkg::BC_WAKE] <= 1'b0;
      end
   end

   // receive line synchroniser, then an edge history
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
         line_prev <= 1'b1;
      end
      else
      begin
         line_meta <= serial_data_pin_i;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end

   // wake detection, only while wake_enable is set in asynchronous mode
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         woke <= 1'b0;
      end
      // R1 R13 first falling transition is the wake event
      else if (baud_ctrl[ubw_pkg::BC_WAKE] && !woke && fall_edge
         && !tx_status[ubw_pkg::TX_SYNC])
      begin
         woke <= 1'b1;
      end
      else if (woke && rise_edge)
      begin
         woke <= 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         receive_irq_flag <= 1'b0;
      end
      // R2 wake sets the flag; set wins over the read clear
      else if (baud_ctrl[ubw_pkg::BC_WAKE] && !woke && fall_edge
         && !tx_status[ubw_pkg::TX_SYNC])
      begin
         receive_irq_flag <= 1'b1;
      end
      // R4 reading receive data clears the flag
      else if (rd && paddr == ubw_pkg::OFS_RX_DATA)
      begin
         receive_irq_flag <= 1'b0;
      end
   end

   // baud generator: one tick every divisor+1 clocks while a frame runs
   always_ff @(posedge clock)
   begin
      if (!rstn || state != UBW_SHIFT)
      begin
         baud_count <= 16'h0000;
         baud_tick <= 1'b0;
      end
      else if (baud_count >= divisor)
      begin
         baud_count <= 16'h0000;
         baud_tick <= 1'b1;
      end
      else
      begin
         baud_count <= baud_count + 16'h0001;
         baud_tick <= 1'b0;
      end
   end

   // holding buffer and its flag
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         transmit_buffer <= ubw_pkg::REG_RESET;
         buffer_full <= 1'b0;
      end
      // R20 only a buffer write empties the flag
      else if (wr && paddr == ubw_pkg::OFS_TX_BUFFER)
      begin
         transmit_buffer <= pwdata[7:0];
         buffer_full <= 1'b1;
      end
      // R19 move to the shifter takes one cycle
      else if (state == UBW_LOAD)
      begin
         buffer_full <= 1'b0;
      end
   end

   // R20 flag set regardless of its enable
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         transmit_irq_flag <= 1'b1;
      end
      else
      begin
         transmit_irq_flag <= !(buffer_full && !(state == UBW_LOAD))
            && !(wr && paddr == ubw_pkg::OFS_TX_BUFFER);
      end
   end

   // transmit sequencer
   always_ff @(posedge clock)
   begin
      if (!rstn || !port_on || !tx_status[ubw_pkg::TX_ENABLE])
      begin
         state <= UBW_IDLE;
         transmit_shifter <= 15'h7fff;
         bits_left <= 4'd0;
         frame_is_break <= 1'b0;
         clk_phase <= 1'b0;
      end
      else
      begin
         unique case (state)
            UBW_IDLE:
            begin
               // R18 reload only with data waiting and shifter idle
               if (buffer_full)
               begin
                  state <= UBW_LOAD;
               end
            end
            UBW_LOAD:
            begin
               state <= UBW_SHIFT;
               clk_phase <= 1'b0;
               frame_is_break <= 1'b0;
               if (sync_master)
               begin
                  // R23 data bits only, lsb first
                  transmit_shifter <= {6'h3f, tx_status[ubw_pkg::TX_NINTH], transmit_buffer};
                  bits_left <= tx_status[ubw_pkg::TX_NINE] ? ubw_pkg::DATA_BITS + 4'd1
                     : ubw_pkg::DATA_BITS;
               end
               // R8 break ignores the written data
               else if (tx_status[ubw_pkg::TX_BREAK])
               begin
                  // R7 start, twelve zeros, stop
                  transmit_shifter <= 15'h2000;
                  bits_left <= ubw_pkg::BREAK_ZEROS + 4'd2;
                  frame_is_break <= 1'b1;
               end
               else
               begin
                  transmit_shifter <= {5'h1f, tx_status[ubw_pkg::TX_NINE]
                     ? tx_status[ubw_pkg::TX_NINTH] : 1'b1, transmit_buffer, 1'b0};
                  bits_left <= tx_status[ubw_pkg::TX_NINE] ? ubw_pkg::DATA_BITS + 4'd3
                     : ubw_pkg::DATA_BITS + 4'd2;
               end
            end
            UBW_SHIFT:
            begin
               if (baud_tick)
               begin
                  // master: two half periods per bit
                  clk_phase <= sync_master ? !clk_phase : 1'b0;
                  if (!sync_master || clk_phase)
                  begin
                     transmit_shifter <= {1'b1, transmit_shifter[14:1]};
                     bits_left <= bits_left - 4'd1;
                     // R18 reload straight away after the last bit
                     if (bits_left == 4'd1)
                     begin
                        state <= buffer_full ? UBW_LOAD : UBW_IDLE;
                     end
                  end
               end
            end
            default: state <= UBW_IDLE;
         endcase
      end
   end

   // pin drivers, registered
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         shift_clock_pin_o <= 1'b1;
         shift_clock_pin_oe <= 1'b0;
         serial_data_pin_o <= 1'b1;
         serial_data_pin_oe <= 1'b0;
      end
      else if (sync_master)
      begin
         // R17 idle level follows clock_polarity
         shift_clock_pin_o <= baud_ctrl[ubw_pkg::BC_POLARITY]
            ^ (state == UBW_SHIFT && clk_phase);
         shift_clock_pin_oe <= 1'b1;
         serial_data_pin_o <= transmit_shifter[0];
         // R16 data pin driven only while sending, so no receive overlaps
         serial_data_pin_oe <= state != UBW_IDLE;
      end
      else
      begin
         // asynchronous line on the clock pin, high when idle
         shift_clock_pin_o <= (state == UBW_SHIFT) ? transmit_shifter[0] : 1'b1;
         shift_clock_pin_oe <= port_on;
         serial_data_pin_o <= 1'b1;
         serial_data_pin_oe <= 1'b0;
      end
   end
endmodule

// *** include/ubw_pkg.sv ***
// constants for the break, wake and synchronous-master serial port
//
// Contract
// R1: wake_enable sits in baud_control bit 1; a falling receive line is a wake event
// R2: while wake_enable is set the port idles; a wake event sets receive_irq_flag
// R3: after a wake event, the next rising receive edge clears wake_enable
// R4: reading receive_data_reg clears the wake-raised receive flag; its data is dummy
// R5: software checks receiver_idle before setting wake_enable ahead of sleep
// R6: wake_enable auto-clear needs no instruction-phase clock, may precede oscillator
// R7: a break is a start bit, twelve zero bits, then a stop bit
// R8: send_break with transmit_enable and a loaded shifter sends zeros, ignoring data
// R9: hardware clears send_break after the break stop bit so queued data follows
// R10: shift_reg_empty shows activity during a break as for normal frames
// R11: header: set enable and break, write dummy byte, then write 55h sync
// R12: a break may be received at 9/13 of the normal baud rate
// R13: with wake enabled, two transitions raise one receive flag, then normal reception
// R14: after a break software may set autobaud_enable once transmit flag is seen
// R15: synchronous master needs clock source, sync select and port enable bits
// R16: synchronous mode is half duplex; transmit and receive exclude each other
// R17: master drives shift clock; clock_polarity set means idle high, clear idle low
// R18: shifter reloads from buffer only after the last bit, then at once
// R19: buffer to shifter move takes one cycle, then buffer empty and flag set
// R20: transmit flag ignores its enable, software cannot clear it, buffer write clears
// R21: shift_reg_empty at transmit status bit 1 is read-only, set when shifter empty
// R22: master setup: divisor, wide select, mode bits, enables, ninth bit, then data
// R23: in synchronous master mode one data bit leaves per baud-set clock period
package ubw_pkg;
   localparam logic [7:0] OFS_RX_STATUS = 8'h00;
   localparam logic [7:0] OFS_TX_BUFFER = 8'h04;
   localparam logic [7:0] OFS_TX_STATUS = 8'h08;
   localparam logic [7:0] OFS_BAUD_CTRL = 8'h0c;
   localparam logic [7:0] OFS_DIV_HIGH = 8'h10;
   localparam logic [7:0] OFS_DIV_LOW = 8'h14;
   localparam logic [7:0] OFS_RX_DATA = 8'h18;
   localparam logic [7:0] OFS_FLAGS = 8'h1c;
   // receive status/control fields
   localparam int RX_PORT_EN = 7;
   // transmit status/control fields
   localparam int TX_CLK_SRC = 7;
   localparam int TX_NINE = 6;
   localparam int TX_ENABLE = 5;
   localparam int TX_SYNC = 4;
   localparam int TX_BREAK = 3;
   localparam int TX_EMPTY = 1;
   localparam int TX_NINTH = 0;
   // baud control fields
   localparam int BC_RX_IDLE = 6;
   localparam int BC_POLARITY = 4;
   localparam int BC_WIDE = 3;
   localparam int BC_WAKE = 1;
   localparam int BC_AUTOBAUD = 0;
   // flag register fields
   localparam int FL_RX = 0;
   localparam int FL_TX = 1;
   localparam int FL_TX_IRQ_EN = 2;
   // writable masks and reset values
   localparam logic [7:0] RX_STATUS_WMASK = 8'h80;
   localparam logic [7:0] TX_STATUS_WMASK = 8'hfd;
   localparam logic [7:0] BAUD_CTRL_WMASK = 8'h1b;
   localparam logic [7:0] TX_STATUS_RESET = 8'h02;
   localparam logic [7:0] REG_RESET = 8'h00;
   // frame lengths in bits, and a cycle count
   localparam logic [3:0] BREAK_ZEROS = 4'd12;
   localparam logic [3:0] DATA_BITS = 4'd8;
   localparam logic [3:0] TCY_CYCLES = 4'd1;
endpackage

// *** verif/ubw_peer.sv ***
// far-side model: serial peer on the receive line, sink for master data
`timescale 1ns/1ns
module ubw_peer
(
   input wire logic sck,
   input wire logic sck_oe,
   input wire logic data,
   input wire logic data_oe,
   input wire logic pol,
   output logic rx_line
);
   logic lclk;
   logic [7:0] sh;
   logic [7:0] q[$];
   int n;
   initial
   begin
      lclk = 1'b0;
      rx_line = 1'b1;
      n = 0;
      #7;
      forever #40 lclk = ~lclk;
   end
   // line moves on the peer's own timebase, unrelated to the port clock
   task set_line(input logic v);
      @(posedge lclk);
      rx_line = v;
   endtask
   // bit taken on the edge leaving idle
   always @(sck)
   begin
      if (sck_oe && data_oe && sck !== pol)
      begin
         sh = {data, sh[7:1]};
         n = n + 1;
         if (n == 8)
         begin
            q.push_back(sh);
            n = 0;
         end
      end
   end
endmodule

// *** verif/ubw_port_properties.sv ***
// assertions on the serial port's pins and register bus
`timescale 1ns/1ns
module ubw_port_properties
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic shift_clock_pin_o,
   input wire logic shift_clock_pin_oe,
   input wire logic serial_data_pin_i,
   input wire logic serial_data_pin_oe,
   input wire logic receive_irq_flag,
   input wire logic transmit_irq_flag
);
   logic tx_wr;
   logic rx_rd;
   assign tx_wr = psel && penable && pready && pwrite && !pslverr
      && paddr == ubw_pkg::OFS_TX_BUFFER;
   assign rx_rd = psel && penable && pready && !pwrite && paddr == ubw_pkg::OFS_RX_DATA;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   chk_tx_flag_clear: assert property (tx_wr |=> !transmit_irq_flag)
      else $error("buffer write left transmit flag set");
   chk_tx_flag_fall: assert property ($fell(transmit_irq_flag) |-> $past(tx_wr))
      else $error("transmit flag fell without buffer write");
   chk_tx_move_delay: assert property ($rose(transmit_irq_flag) |-> !$past(tx_wr))
      else $error("transmit flag rose with no move cycle");
   chk_rx_fall_cause: assert property ($fell(receive_irq_flag) |-> $past(rx_rd))
      else $error("receive flag fell without data read");
   chk_rx_read_clear: assert property (rx_rd && serial_data_pin_i && $past(serial_data_pin_i)
      && $past(serial_data_pin_i, 2) && $past(serial_data_pin_i, 3) |=> !receive_irq_flag)
      else $error("data read left receive flag set");
   chk_wake_edge: assert property ($rose(receive_irq_flag) |-> !$past(serial_data_pin_i, 2)
      || !$past(serial_data_pin_i, 3) || !$past(serial_data_pin_i, 4))
      else $error("receive flag rose without falling line");
   chk_data_with_clk: assert property (serial_data_pin_oe |-> shift_clock_pin_oe)
      else $error("data driven without shift clock");
   chk_frame_idle: assert property ($rose(serial_data_pin_oe) |-> $stable(shift_clock_pin_o))
      else $error("shift clock not idle at frame start");
endmodule
bind ubw_port ubw_port_properties chk (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
   .pready, .pslverr, .shift_clock_pin_o, .shift_clock_pin_oe, .serial_data_pin_i,
   .serial_data_pin_oe, .receive_irq_flag, .transmit_irq_flag);

// *** verif/tb_uart_break_wake_sync_master_tx.sv ***
// self-checking bench for the break, wake and sync-master serial port
`timescale 1ns/1ns
module tb_uart_break_wake_sync_master_tx;
   logic clock, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic sck, sck_oe, dt_o, dt_oe, dt, rx_line, pol, e, rxf, txf;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   ubw_port uut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .shift_clock_pin_o(sck), .shift_clock_pin_oe(sck_oe), .serial_data_pin_i(dt),
      .serial_data_pin_o(dt_o), .serial_data_pin_oe(dt_oe), .receive_irq_flag(rxf),
      .transmit_irq_flag(txf));
   // shared data pin: the port wins while it drives
   assign dt = dt_oe ? dt_o : rx_line;
   ubw_peer peer (.sck(sck), .sck_oe(sck_oe), .data(dt), .data_oe(dt_oe), .pol(pol),
      .rx_line(rx_line));
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task conclude;
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         conclude;
      end
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(r, exp);
   endtask
   task t_reset;
      wr(ubw_pkg::OFS_TX_STATUS, 32'h0);
      rd(ubw_pkg::OFS_TX_STATUS, 32'h2);
      rd(ubw_pkg::OFS_FLAGS, 32'h2);
      rd(8'h20, 32'h0);
      cmp({31'h0, e}, 32'h1);
   endtask
   task t_wake;
      wr(ubw_pkg::OFS_RX_STATUS, 32'h80);
      rd(ubw_pkg::OFS_BAUD_CTRL, 32'h40);
      wr(ubw_pkg::OFS_BAUD_CTRL, 32'h2);
      peer.set_line(1'b0); // break starts: line held low
      repeat (8) @(posedge clock);
      cmp({31'h0, rxf}, 32'h1);
      rd(ubw_pkg::OFS_BAUD_CTRL, 32'h2);
      peer.set_line(1'b1);
      repeat (8) @(posedge clock);
      apb(1'b0, ubw_pkg::OFS_BAUD_CTRL, 32'h0);
      cmp(r & 32'h2, 32'h0);
      rd(ubw_pkg::OFS_RX_DATA, 32'h0);
      rd(ubw_pkg::OFS_FLAGS, 32'h2);
   endtask
   // samples the transmit line mid-bit, eight clocks per bit
   task cap(output logic [23:0] v);
      for (int i = 0; i < 400 && sck !== 1'b0; i++)
         @(posedge clock);
      repeat (4) @(posedge clock);
      for (int i = 0; i < 24; i++)
      begin
         v[i] = sck;
         repeat (8) @(posedge clock);
      end
   endtask
   task t_break;
      logic [23:0] v;
      wr(ubw_pkg::OFS_DIV_LOW, 32'h7);
      wr(ubw_pkg::OFS_TX_STATUS, 32'h28);
      wr(ubw_pkg::OFS_TX_BUFFER, 32'hff);
      fork
         cap(v);
         begin
            wr(ubw_pkg::OFS_TX_BUFFER, 32'h55);
            rd(ubw_pkg::OFS_TX_STATUS, 32'h28);
            cmp({31'h0, txf}, 32'h0);
         end
      join
      cmp({8'h0, v}, {8'h0, 1'b1, 8'h55, 1'b0, 1'b1, 13'h0});
      repeat (16) @(posedge clock);
      rd(ubw_pkg::OFS_TX_STATUS, 32'h22);
      cmp({31'h0, txf}, 32'h1);
      wr(ubw_pkg::OFS_BAUD_CTRL, 32'h1);
      rd(ubw_pkg::OFS_BAUD_CTRL, 32'h41);
   endtask
   // nine-bit asynchronous frame with the wide divisor selected
   task t_nine;
      logic [23:0] v;
      wr(ubw_pkg::OFS_DIV_LOW, 32'h7);
      wr(ubw_pkg::OFS_TX_STATUS, 32'h60);
      wr(ubw_pkg::OFS_BAUD_CTRL, 32'h8);
      fork
         cap(v);
         wr(ubw_pkg::OFS_TX_BUFFER, 32'h3c);
      join
      cmp({8'h0, v}, {8'h0, 13'h1fff, 1'b1, 1'b0, 8'h3c, 1'b0});
   endtask
   task t_sync;
      wr(ubw_pkg::OFS_DIV_LOW, 32'h1);
      for (int p = 1; p >= 0; p--)
      begin
         pol = p[0];
         wr(ubw_pkg::OFS_BAUD_CTRL, {27'h0, pol, 4'h0});
         wr(ubw_pkg::OFS_TX_STATUS, 32'hb0);
         wr(ubw_pkg::OFS_TX_BUFFER, 32'ha5);
         wr(ubw_pkg::OFS_TX_BUFFER, 32'h3c);
         for (int i = 0; i < 400 && peer.q.size() < 2; i++)
            @(posedge clock);
         repeat (8) @(posedge clock);
         cmp({24'h0, peer.q.pop_front()}, 32'ha5);
         cmp({24'h0, peer.q.pop_front()}, 32'h3c);
         cmp({30'h0, sck, dt_oe}, {30'h0, pol, 1'b0});
      end
   endtask
   initial
   begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pol = 1'b0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      t_reset;
      t_wake;
      t_break;
      t_sync;
      t_nine;
      conclude;
   end
endmodule
